// ===== rtl/hzc_pkg.sv
// Purpose: Constants of the hazard control.
// Assumes: 32-bit register bus.
// Notes:   Offsets are byte addresses.
package hzc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  OFF_CTRL     = 8'h00; // Count stop, boot vector.
    localparam logic [7:0]  OFF_VBASE    = 8'h04; // Exception vector base.
    localparam logic [7:0]  OFF_COUNT    = 8'h08; // Cycle counter, stops while CTRL_STOP is set.
    localparam logic [7:0]  OFF_STATUS   = 8'h0C; // Status as executed.
    localparam logic [7:0]  OFF_CAUSE    = 8'h10; // Visible cause bits.
    localparam int          CTRL_STOP    = 0;     // Counter stop bit.
    localparam int          CTRL_BOOT    = 1;     // Boot vector select bit.
    localparam logic [31:0] VBASE_RST    = 32'h0000_0000;
    localparam logic [31:0] BOOT_BASE    = 32'h0000_1000; // Fixed boot base.
    localparam int          VEC_SHIFT    = 5;     // Bytes per vector, log2.

    // ----------------------------------------------------------------
    // Selects and fields
    // ----------------------------------------------------------------
    localparam logic [4:0]  SEL_COMPARE  = 5'h0B;
    localparam logic [4:0]  SEL_STATUS   = 5'h0C;
    localparam logic [4:0]  SEL_CAUSE    = 5'h0D;
    localparam logic [4:0]  SEL_EPC      = 5'h0E;
    localparam logic [4:0]  SEL_SHADOW   = 5'h0F;
    localparam int          USABLE_BIT   = 28;    // System coprocessor usable.
    localparam int          GIE_BIT      = 0;     // Global interrupt enable.
    localparam int          ERRLVL_BIT   = 2;     // Error level.
    localparam int          PSS_LSB      = 6;     // Previous shadow set field.
    localparam int          PSS_W        = 4;
    localparam int          SOFT_W       = 2;     // Soft request bits 1:0.
    localparam int          TPEND_BIT    = 30;    // Timer pending in cause view.
    localparam logic [31:0] STATUS_RST   = 32'h0000_0004;

    // ----------------------------------------------------------------
    // Spacing in retires
    // ----------------------------------------------------------------
    localparam int          SP_FAST      = 1;     // Usable bit and enable bit.
    localparam int          SP_EPC       = 1;
    localparam int          SP_PSS       = 1;
    localparam int          SP_SOFT      = 3;
    localparam int          SP_TIMER     = 4;
    localparam int          SP_OTHER     = 2;

    // ----------------------------------------------------------------
    // Bypass choices
    // ----------------------------------------------------------------
    localparam logic [1:0]  BYP_NONE     = 2'h0;
    localparam logic [1:0]  BYP_MEM      = 2'h1;
    localparam logic [1:0]  BYP_ALIGN    = 2'h2;

endpackage

// ===== rtl/hzc_delay.sv
// Purpose: Delays a written value by retires.
// Assumes: The write's own retire is not counted.
// Notes:   A barrier releases at once.
`timescale 1ns/100ps
`default_nettype none
module hzc_delay #(
    parameter int          W   = 32,
    parameter int          SP  = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst,
    // Write and pipeline events.
    input  wire logic         load,
    input  wire logic [W-1:0] data,
    input  wire logic         retire,
    input  wire logic         flush,
    // Visible value.
    output logic      [W-1:0] vis,
    output logic              busy,
    output logic              done
);
    // State of one delayed register.
    typedef struct packed {
        logic [W-1:0] pend;  // Value waiting to be seen.
        logic [W-1:0] vis;   // Value seen by dependents.
        logic [2:0]   cnt;   // Retires still to go.
        logic         busy;  // A value is waiting.
        logic         done;  // Pulse when a value became visible.
    } hzc_dly_t;

    localparam logic [2:0] CNT_ONE = 3'h1;
    localparam hzc_dly_t   DLY_RST = '{vis: RST, default: '0};

    hzc_dly_t q;
    hzc_dly_t d;

    // Count retires; release on the last.
    always_comb begin
        d      = q;
        d.done = 1'b0;
        if (load) begin
            d.pend = data;
            d.cnt  = 3'(SP);
            d.busy = (SP != 0);
            if (SP == 0) begin
                d.vis  = data;
                d.done = 1'b1;
            end
        end else if (q.busy) begin
            // Early release on a barrier is allowed, late never.
            if (flush || (retire && q.cnt == CNT_ONE)) begin
                d.vis  = q.pend;
                d.busy = 1'b0;
                d.done = 1'b1;
            end else if (retire) begin
                d.cnt = q.cnt - CNT_ONE;
            end
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= DLY_RST;
        end else begin
            q <= d;
        end
    end

    assign vis  = q.vis;
    assign busy = q.busy;
    assign done = q.done;
endmodule // hzc_delay
`default_nettype wire

// ===== rtl/hzc_ctrl.sv
// Purpose: Hazard spacing and split bus ports.
// Assumes: Events are one-cycle pulses.
// Notes:   Bus routing lies outside.
// Operation
// - Return PC after 1, status at once
// - Usable bit acts after 1
// - Atomic enable/disable, effect after 1
// - Soft requests act after 3
// - Shadow set field seen after 1
// - Compare clears timer after 4
// - Other registers seen after 2
// - Fetch sees status writes
// - Barrier completes pending changes
// - Boot select low uses vector base
// - Take external vectors
// - Counter can be stopped
// - Separate fetch and data ports
// - All fetches use fetch port
// - Loads and stores on data port
// - Slips only, forward memory and align
`timescale 1ns/100ps
`default_nettype none
module hzc_ctrl
    import hzc_pkg::*;
(
    // Clock and reset.
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // Register bus slave.
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic      [31:0] HRDATA,
    output logic             HRESP,
    // Retire and coprocessor write events.
    input  wire logic        RETIRE,
    input  wire logic        CP_WR,
    input  wire logic [4:0]  CP_SEL,
    input  wire logic [31:0] CP_DATA,
    input  wire logic        INT_ENABLE_OP,
    input  wire logic        INT_DISABLE_OP,
    input  wire logic        HAZARD_BARRIER,
    input  wire logic        EXC_RETURN,
    // Interrupt vectors and timer.
    input  wire logic        EXT_VEC_VALID,
    input  wire logic [5:0]  EXT_VEC_NUM,
    input  wire logic        TIMER_MATCH,
    // Visible control state.
    output logic      [31:0] PREV_STATUS,
    output logic             COPROC_USABLE,
    output logic             INT_ACCEPT_EN,
    output logic      [1:0]  SOFT_INT_REQ,
    output logic      [3:0]  PREV_SHADOW_SET,
    output logic             TIMER_INT,
    output logic      [31:0] FETCH_STATUS,
    output logic      [4:0]  GEN_SEL,
    output logic      [31:0] GEN_DATA,
    output logic             HAZARD_BUSY,
    output logic             REDIRECT,
    output logic      [31:0] REDIRECT_PC,
    output logic             VEC_ACK,
    // Instruction side, fed by the fetch stage.
    input  wire logic        FETCH_REQ,
    input  wire logic [31:0] FETCH_ADDR,
    input  wire logic        I_FAULT,
    output logic             I_REQ,
    output logic      [31:0] I_ADDR,
    output logic             FETCH_FAULT,
    // Data side, fed by the memory stage.
    input  wire logic        MEM_REQ,
    input  wire logic        MEM_WE,
    input  wire logic [31:0] MEM_ADDR,
    input  wire logic [31:0] MEM_WDATA,
    input  wire logic        D_ACK,
    input  wire logic [31:0] D_RDATA,
    output logic             D_REQ,
    output logic             D_WE,
    output logic      [31:0] D_ADDR,
    output logic      [31:0] D_WDATA,
    output logic             LOAD_VALID,
    output logic      [31:0] LOAD_DATA,
    // Operand forwarding.
    input  wire logic [4:0]  EXE_SRC,
    input  wire logic        MEM_DST_WE,
    input  wire logic [4:0]  MEM_DST,
    input  wire logic        ALN_DST_WE,
    input  wire logic [4:0]  ALN_DST,
    output logic      [1:0]  BYPASS_SEL
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] status;     // Executing status.
        logic [31:0] prev_stat;  // Status before atomic op.
        logic        stop;       // Counter stopped.
        logic        boot;       // Fixed boot vectors selected.
        logic [31:0] vbase;      // Vector base.
        logic [31:0] count;      // Cycle counter.
        logic        tpend;      // Timer interrupt pending.
        logic        wpend;      // Bus write in data phase.
        logic [7:0]  waddr;      // Its address.
        logic [31:0] hrdata;     // Read data.
        logic        hready;     // Slave ready.
        logic        redir;      // Redirect pulse.
        logic [31:0] redir_pc;   // Target of the redirect.
        logic        vack;       // Vector taken pulse.
        logic        i_req;      // Instruction port request.
        logic [31:0] i_addr;
        logic        i_fault;
        logic        d_req;      // Data port request.
        logic        d_we;
        logic [31:0] d_addr;
        logic [31:0] d_wdata;
        logic        ld_valid;
        logic [31:0] ld_data;
        logic [1:0]  byp;        // Operand forwarding choice.
    } hzc_top_t;

    localparam hzc_top_t TOP_RST = '{status: STATUS_RST, boot: 1'b1,
                                     vbase: VBASE_RST, hready: 1'b1,
                                     default: '0};

    hzc_top_t q;
    hzc_top_t d;

    // Write decode of the coprocessor register selects.
    logic        wr_status;
    logic        wr_cause;
    logic        wr_epc;
    logic        wr_shadow;
    logic        wr_compare;
    logic        wr_other;
    logic        fast_load;   // Usable or enable bit changed.
    logic [1:0]  fast_vis;    // Bit 1 usable, bit 0 enable.
    logic [31:0] epc_vis;
    logic [1:0]  soft_vis;
    logic [3:0]  pss_vis;
    logic [31:0] fstat_vis;
    logic [36:0] gen_vis;
    logic [5:0]  busy;
    logic        cmp_done;
    logic [31:0] stat_nxt;

    // ----------------------------------------------------------------
    // Coprocessor write decode
    // ----------------------------------------------------------------
    assign wr_status  = CP_WR && (CP_SEL == SEL_STATUS);
    assign wr_cause   = CP_WR && (CP_SEL == SEL_CAUSE);
    assign wr_epc     = CP_WR && (CP_SEL == SEL_EPC);
    assign wr_shadow  = CP_WR && (CP_SEL == SEL_SHADOW);
    assign wr_compare = CP_WR && (CP_SEL == SEL_COMPARE);
    assign wr_other   = CP_WR && !wr_status && !wr_cause && !wr_epc
                        && !wr_shadow && !wr_compare;
    assign fast_load  = wr_status || INT_ENABLE_OP || INT_DISABLE_OP;

    // Next status after ops or a write.
    always_comb begin
        stat_nxt = q.status;
        if (wr_status) begin
            stat_nxt = CP_DATA;
        end else if (INT_ENABLE_OP) begin
            stat_nxt[GIE_BIT] = 1'b1;
        end else if (INT_DISABLE_OP) begin
            stat_nxt[GIE_BIT] = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Delayed views, one per spacing class, two for SP_OTHER
    // ----------------------------------------------------------------
    // Usable and enable bits, after 1.
    hzc_delay #(.W(2), .SP(SP_FAST), .RST(2'h0)) u_fast (
        .clk(CLK),
        .rst(SYS_RST),
        .load(fast_load),
        .data({stat_nxt[USABLE_BIT], stat_nxt[GIE_BIT]}),
        .retire(RETIRE),
        .flush(HAZARD_BARRIER),
        .vis(fast_vis),
        .busy(busy[0]),
        .done()
    );

    // Return address.
    hzc_delay #(.W(32), .SP(SP_EPC), .RST(32'h0)) u_epc (
        .clk(CLK),
        .rst(SYS_RST),
        .load(wr_epc),
        .data(CP_DATA),
        .retire(RETIRE),
        .flush(HAZARD_BARRIER),
        .vis(epc_vis),
        .busy(busy[1]),
        .done()
    );

    // Software interrupt request bits.
    hzc_delay #(.W(SOFT_W), .SP(SP_SOFT), .RST(2'h0)) u_soft (
        .clk(CLK),
        .rst(SYS_RST),
        .load(wr_cause),
        .data(CP_DATA[SOFT_W-1:0]),
        .retire(RETIRE),
        .flush(HAZARD_BARRIER),
        .vis(soft_vis),
        .busy(busy[2]),
        .done()
    );

    // Previous shadow set.
    hzc_delay #(.W(PSS_W), .SP(SP_PSS), .RST(4'h0)) u_pss (
        .clk(CLK),
        .rst(SYS_RST),
        .load(wr_shadow),
        .data(CP_DATA[PSS_LSB +: PSS_W]),
        .retire(RETIRE),
        .flush(HAZARD_BARRIER),
        .vis(pss_vis),
        .busy(busy[3]),
        .done()
    );

    // Compare write clears the timer.
    hzc_delay #(.W(1), .SP(SP_TIMER), .RST(1'b0)) u_cmp (
        .clk(CLK),
        .rst(SYS_RST),
        .load(wr_compare),
        .data(1'b1),
        .retire(RETIRE),
        .flush(HAZARD_BARRIER),
        .vis(),
        .busy(busy[4]),
        .done(cmp_done)
    );

    // Any other register, status too.
    hzc_delay #(.W(37), .SP(SP_OTHER), .RST({5'h0, STATUS_RST})) u_gen (
        .clk(CLK),
        .rst(SYS_RST),
        .load(wr_other || wr_status),
        .data({CP_SEL, CP_DATA}),
        .retire(RETIRE),
        .flush(HAZARD_BARRIER),
        .vis(gen_vis),
        .busy(busy[5]),
        .done()
    );

    // Status as fetch sees it.
    hzc_delay #(.W(32), .SP(SP_OTHER), .RST(STATUS_RST)) u_fst (
        .clk(CLK),
        .rst(SYS_RST),
        .load(wr_status),
        .data(CP_DATA),
        .retire(RETIRE),
        .flush(HAZARD_BARRIER),
        .vis(fstat_vis),
        .busy(),
        .done()
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        d          = q;
        d.redir    = 1'b0;
        d.vack     = 1'b0;
        d.hready   = 1'b1;
        d.hrdata   = 32'h0000_0000;
        d.wpend    = 1'b0;

        // Execution view of status: seen with no spacing.
        d.status = stat_nxt;
        if (INT_ENABLE_OP || INT_DISABLE_OP) begin
            d.prev_stat = q.status;
        end

        // Counter runs unless software stopped it.
        if (!q.stop) begin
            d.count = q.count + 32'h0000_0001;
        end

        // A new match wins over a clear in the same cycle.
        d.tpend = (q.tpend && !cmp_done) || TIMER_MATCH;

        // Exception return goes before a new vector.
        if (EXC_RETURN) begin
            d.redir    = 1'b1;
            d.redir_pc = epc_vis;
        end else if (EXT_VEC_VALID && fast_vis[0]) begin
            d.redir = 1'b1;
            d.vack  = 1'b1;
            d.redir_pc = (q.boot ? BOOT_BASE : q.vbase)
                         + {21'h0, EXT_VEC_NUM, 5'h00};
        end

        // Data phase of a bus write.
        if (q.wpend) begin
            if (q.waddr == OFF_CTRL) begin
                d.stop = HWDATA[CTRL_STOP];
                d.boot = HWDATA[CTRL_BOOT];
            end else if (q.waddr == OFF_VBASE) begin
                d.vbase = HWDATA;
            end
        end

        // Address phase: latch writes, prepare read data.
        if (HSEL && HREADY && HTRANS[1]) begin
            if (HWRITE) begin
                d.wpend = 1'b1;
                d.waddr = HADDR[7:0];
            end else if (HADDR[7:0] == OFF_CTRL) begin
                d.hrdata[CTRL_STOP] = q.stop;
                d.hrdata[CTRL_BOOT] = q.boot;
            end else if (HADDR[7:0] == OFF_VBASE) begin
                d.hrdata = q.vbase;
            end else if (HADDR[7:0] == OFF_COUNT) begin
                d.hrdata = q.count;
            end else if (HADDR[7:0] == OFF_STATUS) begin
                d.hrdata = q.status;
            end else if (HADDR[7:0] == OFF_CAUSE) begin
                d.hrdata[SOFT_W-1:0] = soft_vis;
                d.hrdata[TPEND_BIT]  = q.tpend;
            end
        end

        // Instruction port: every fetch, whatever its address.
        d.i_req   = FETCH_REQ;
        d.i_addr  = FETCH_ADDR;
        d.i_fault = I_FAULT;

        // Data port: every load and store from the memory stage.
        d.d_req    = MEM_REQ;
        d.d_we     = MEM_WE;
        d.d_addr   = MEM_ADDR;
        d.d_wdata  = MEM_WDATA;
        d.ld_valid = D_ACK;
        d.ld_data  = D_RDATA;

        // Forwarding: the memory stage is newer than align.
        d.byp = BYP_NONE;
        if (MEM_DST_WE && MEM_DST == EXE_SRC && EXE_SRC != 5'h00) begin
            d.byp = BYP_MEM;
        end else if (ALN_DST_WE && ALN_DST == EXE_SRC
                     && EXE_SRC != 5'h00) begin
            d.byp = BYP_ALIGN;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            q <= TOP_RST;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs from flip-flops; HRESP tied low, HAZARD_BUSY an OR of busy flags
    // ----------------------------------------------------------------
    assign HREADYOUT       = q.hready;
    assign HRDATA          = q.hrdata;
    assign HRESP           = 1'b0;
    assign PREV_STATUS     = q.prev_stat;
    assign COPROC_USABLE   = fast_vis[1];
    assign INT_ACCEPT_EN   = fast_vis[0];
    assign SOFT_INT_REQ    = soft_vis;
    assign PREV_SHADOW_SET = pss_vis;
    assign TIMER_INT       = q.tpend;
    assign FETCH_STATUS    = fstat_vis;
    assign GEN_SEL         = gen_vis[36:32];
    assign GEN_DATA        = gen_vis[31:0];
    assign HAZARD_BUSY     = |busy;
    assign REDIRECT        = q.redir;
    assign REDIRECT_PC     = q.redir_pc;
    assign VEC_ACK         = q.vack;
    assign I_REQ           = q.i_req;
    assign I_ADDR          = q.i_addr;
    assign FETCH_FAULT     = q.i_fault;
    assign D_REQ           = q.d_req;
    assign D_WE            = q.d_we;
    assign D_ADDR          = q.d_addr;
    assign D_WDATA         = q.d_wdata;
    assign LOAD_VALID      = q.ld_valid;
    assign LOAD_DATA       = q.ld_data;
    assign BYPASS_SEL      = q.byp;

endmodule // hzc_ctrl
`default_nettype wire

// ===== dv/hzc_props.sv
// Purpose: Port assertions.
// Assumes: One clock.
// Notes:   Bound to the control block.
`timescale 1ns/100ps
`default_nettype none
module hzc_props (
    // Watched ports.
    input wire logic        CLK, SYS_RST, FETCH_REQ, I_REQ, MEM_REQ, D_REQ, CP_WR,
    input wire logic        TIMER_MATCH, TIMER_INT, EXC_RETURN, REDIRECT, RETIRE,
    input wire logic        HAZARD_BARRIER, HAZARD_BUSY, INT_ACCEPT_EN,
    input wire logic [1:0]  SOFT_INT_REQ,
    input wire logic [31:0] FETCH_ADDR, I_ADDR, MEM_ADDR, D_ADDR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // Both ports asked for in one cycle.
    sequence s_both; FETCH_REQ && MEM_REQ; endsequence
    property p_split; s_both |=> I_REQ && D_REQ; endproperty
    property p_iport; FETCH_REQ |=> I_REQ && I_ADDR == $past(FETCH_ADDR); endproperty
    property p_dport; MEM_REQ |=> D_REQ && D_ADDR == $past(MEM_ADDR); endproperty
    property p_tmr; TIMER_MATCH |=> TIMER_INT; endproperty
    property p_ret; EXC_RETURN |=> REDIRECT; endproperty
    property p_bar; HAZARD_BARRIER && !CP_WR |=> !HAZARD_BUSY; endproperty
    // A visible value moves only on a retire or a barrier.
    property p_soft; $changed(SOFT_INT_REQ) |->
        $past(RETIRE || HAZARD_BARRIER) || $past(HAZARD_BARRIER, 2); endproperty
    property p_ie; $changed(INT_ACCEPT_EN) |->
        $past(RETIRE || HAZARD_BARRIER) || $past(HAZARD_BARRIER, 2); endproperty
    a_split: assert property (p_split) else $error("ports not parallel");
    a_iport: assert property (p_iport) else $error("fetch port");
    a_dport: assert property (p_dport) else $error("data port");
    a_tmr: assert property (p_tmr) else $error("timer pending");
    a_ret: assert property (p_ret) else $error("return redirect");
    a_bar: assert property (p_bar) else $error("barrier");
    a_soft: assert property (p_soft) else $error("soft request early");
    a_ie: assert property (p_ie) else $error("enable early");
endmodule // hzc_props
bind hzc_ctrl hzc_props u_props (.*);
`default_nettype wire

// ===== dv/hzc_matrix.sv
// Purpose: Bus matrix model.
// Assumes: One data RAM of 16 words.
// Notes:   WAIT cycles before each answer.
`timescale 1ns/100ps
`default_nettype none
module hzc_matrix #(parameter int WAIT = 2) (
    input wire logic        clk, d_req, d_we, i_req,
    input wire logic [31:0] d_addr, d_wdata, i_addr,
    output logic            d_ack, i_fault,
    output logic [31:0]     d_rdata
);
    logic [31:0] mem [16];
    logic [31:0] a, wd;
    logic        pend, we;
    int          cnt;
    initial {d_ack, i_fault, d_rdata, pend, cnt} = '0;
    // Fetches with the top address bit set raise an exception.
    always @(posedge clk) i_fault <= i_req && i_addr[31];
    // Data path: one target, read data never held between answers.
    always @(posedge clk) begin
        d_ack <= 1'b0;
        d_rdata <= ~d_rdata;
        if (d_req) begin
            {pend, we, a, wd, cnt} <= {1'b1, d_we, d_addr, d_wdata, 32'h0};
        end else if (pend && cnt < WAIT) begin
            cnt <= cnt + 1;
        end else if (pend) begin
            {pend, d_ack, d_rdata} <= {1'b0, 1'b1, mem[a[5:2]]};
            if (we) mem[a[5:2]] <= wd;
        end
    end
endmodule // hzc_matrix
`default_nettype wire

// ===== dv/hzc_ctrl_bench.sv
// Purpose: Self-checking bench.
// Assumes: Zero-wait register slave.
// Notes:   Each test task judges its results.
`timescale 1ns/100ps
`default_nettype none
module hzc_ctrl_bench import hzc_pkg::*; ;
    logic CLK, SYS_RST, HSEL, HWRITE, HREADY, RETIRE, CP_WR, INT_ENABLE_OP, INT_DISABLE_OP;
    logic HAZARD_BARRIER, EXC_RETURN, EXT_VEC_VALID, TIMER_MATCH, FETCH_REQ, I_FAULT, MEM_REQ;
    logic MEM_WE, D_ACK, MEM_DST_WE, ALN_DST_WE, HREADYOUT, HRESP, COPROC_USABLE, INT_ACCEPT_EN;
    logic TIMER_INT, HAZARD_BUSY, REDIRECT, VEC_ACK, I_REQ, FETCH_FAULT, D_REQ, D_WE, LOAD_VALID;
    logic [1:0] HTRANS, SOFT_INT_REQ, BYPASS_SEL;
    logic [2:0] HSIZE;
    logic [3:0] PREV_SHADOW_SET;
    logic [4:0] CP_SEL, GEN_SEL, EXE_SRC, MEM_DST, ALN_DST;
    logic [5:0] EXT_VEC_NUM;
    logic [31:0] HADDR, HWDATA, HRDATA, CP_DATA, PREV_STATUS, FETCH_STATUS, GEN_DATA, D_RDATA;
    logic [31:0] REDIRECT_PC, FETCH_ADDR, I_ADDR, MEM_ADDR, MEM_WDATA, D_ADDR, D_WDATA, LOAD_DATA;
    int error_cnt = 0, check_count = 0, cyc = 0;
    // Coprocessor writes: select, data, retires before it must show.
    logic [4:0] t_sel [5] = '{SEL_CAUSE, SEL_SHADOW, SEL_STATUS, SEL_COMPARE, 5'h01};
    logic [31:0] t_dat [5] = '{32'h3, 32'h240, 32'h1000_0001, 32'h0, 32'h5A5A_A5A5};
    int t_sp [5] = '{SP_SOFT, SP_PSS, SP_OTHER, SP_TIMER, SP_OTHER};
    assign HREADY = HREADYOUT;
    hzc_ctrl dut (.*);
    hzc_matrix #(.WAIT(2)) u_mx (.clk(CLK), .d_req(D_REQ), .d_we(D_WE), .i_req(I_REQ),
        .d_addr(D_ADDR), .d_wdata(D_WDATA), .i_addr(I_ADDR), .d_ack(D_ACK),
        .i_fault(I_FAULT), .d_rdata(D_RDATA));
    initial begin
        CLK = 0;
        forever #5 CLK = ~CLK;
    end
    task close_out;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge CLK) if (++cyc == 5000) begin error_cnt++; close_out(); end
    task chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, g); end
    endtask
    // Register bus single word transfer.
    task automatic ahb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
        @(posedge CLK) {HSEL, HTRANS, HADDR, HWRITE} <= {1'b1, 2'h2, 24'h0, a, w};
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        {HSEL, HTRANS, HWDATA} <= {1'b0, 2'h0, d};
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        r = HRDATA;
    endtask
    task cpw(logic [4:0] s, logic [31:0] d);
        @(posedge CLK) {CP_WR, CP_SEL, CP_DATA} <= {1'b1, s, d};
        @(posedge CLK) CP_WR <= 0;
    endtask
    task ret(int n);
        repeat (n) begin RETIRE <= 1; @(posedge CLK); end
        RETIRE <= 0;
        @(posedge CLK) #1;
    endtask
    task vec;
        {EXT_VEC_VALID, EXT_VEC_NUM} <= {1'b1, 6'h3};
        @(posedge CLK) EXT_VEC_VALID <= 0;
        #1;
    endtask
    function logic [31:0] obs(logic [4:0] s);
        case (s)
            SEL_CAUSE: return {30'h0, SOFT_INT_REQ};
            SEL_SHADOW: return {22'h0, PREV_SHADOW_SET, 6'h0};
            SEL_STATUS: return {3'h0, COPROC_USABLE, FETCH_STATUS[27:1], INT_ACCEPT_EN};
            SEL_COMPARE: return {31'h0, TIMER_INT};
            default: return GEN_DATA;
        endcase
    endfunction
    task t_regs;
        logic [31:0] r, c;
        ahb(0, OFF_CTRL, 0, r); chk("ctrl", 32'h2, r);
        ahb(1, OFF_STATUS, 32'hFFFF_FFFF, r); ahb(0, OFF_STATUS, 0, r); chk("status", STATUS_RST, r);
        ahb(0, 8'h40, 0, r); chk("unmapped", 32'h0, r);
        ahb(1, OFF_CTRL, 32'h1, r); ahb(0, OFF_COUNT, 0, c); ahb(0, OFF_COUNT, 0, r);
        chk("count", c, r);
    endtask
    task t_hz;
        for (int i = 0; i < 5; i++) begin
            if (t_sel[i] == SEL_COMPARE) begin
                @(posedge CLK) TIMER_MATCH <= 1;
                @(posedge CLK) TIMER_MATCH <= 0;
            end
            cpw(t_sel[i], t_dat[i]);
            ret(t_sp[i]);
            chk("visible", t_dat[i], obs(t_sel[i]));
        end
    endtask
    task t_ret;
        cpw(SEL_EPC, 32'h2000); ret(SP_EPC);
        EXC_RETURN <= 1;
        @(posedge CLK) EXC_RETURN <= 0;
        #1 chk("return pc", 32'h2000, REDIRECT_PC);
    endtask
    task t_vec;
        logic [31:0] r;
        ahb(1, OFF_CTRL, 0, r); ahb(1, OFF_VBASE, 32'h400, r);
        @(posedge CLK) INT_ENABLE_OP <= 1;
        @(posedge CLK) INT_ENABLE_OP <= 0;
        ret(SP_FAST); vec(); chk("vector", 32'h400 + (3 << VEC_SHIFT), REDIRECT_PC);
        chk("ack", 1, VEC_ACK);
        @(posedge CLK) INT_DISABLE_OP <= 1;
        @(posedge CLK) INT_DISABLE_OP <= 0;
        #1 chk("prev status", 1, PREV_STATUS[GIE_BIT]);
        ret(SP_FAST); vec(); chk("masked", 0, VEC_ACK);
    endtask
    task t_ports;
        {FETCH_REQ, FETCH_ADDR, MEM_REQ, MEM_WE} <= {1'b1, 32'h8000_0010, 1'b1, 1'b1};
        {MEM_ADDR, MEM_WDATA} <= {32'h8, 32'hC0DE_0001};
        @(posedge CLK) {FETCH_REQ, MEM_REQ} <= 2'h0;
        repeat (2) @(posedge CLK);
        #1 chk("fetch fault", 1, FETCH_FAULT);
        repeat (6) @(posedge CLK);
        {MEM_REQ, MEM_WE} <= 2'h2;
        @(posedge CLK) MEM_REQ <= 0;
        repeat (20) begin @(posedge CLK); if (LOAD_VALID === 1'b1) break; end
        chk("load", 32'hC0DE_0001, LOAD_DATA);
    endtask
    task t_byp;
        {EXE_SRC, MEM_DST_WE, MEM_DST, ALN_DST_WE, ALN_DST} <= {5'h05, 1'b1, 5'h05, 1'b1, 5'h05};
        @(posedge CLK) #1 chk("mem bypass", BYP_MEM, BYPASS_SEL);
        MEM_DST <= 5'h06;
        @(posedge CLK) #1 chk("align bypass", BYP_ALIGN, BYPASS_SEL);
    endtask
    task t_bar;
        cpw(5'h02, 32'h1234_5678);
        HAZARD_BARRIER <= 1;
        @(posedge CLK) HAZARD_BARRIER <= 0;
        @(posedge CLK) #1 chk("barrier", 32'h1234_5678, GEN_DATA);
        chk("gen sel", 2, GEN_SEL);
    endtask
    initial begin
        {HSEL, HWRITE, RETIRE, CP_WR, INT_ENABLE_OP, INT_DISABLE_OP, HAZARD_BARRIER, EXC_RETURN,
         EXT_VEC_VALID, TIMER_MATCH, FETCH_REQ, MEM_REQ, MEM_WE, MEM_DST_WE, ALN_DST_WE, HTRANS,
         CP_SEL, EXE_SRC, MEM_DST, ALN_DST, EXT_VEC_NUM, HADDR, HWDATA, CP_DATA, FETCH_ADDR,
         MEM_ADDR, MEM_WDATA} = '0;
        HSIZE = 3'h2;
        SYS_RST = 1;
        repeat (6) @(posedge CLK);
        SYS_RST <= 0;
        t_regs(); t_hz(); t_ret(); t_vec(); t_ports(); t_byp(); t_bar();
        close_out();
    end
endmodule // hzc_ctrl_bench
`default_nettype wire
